//--- inc/pmu_alarm_regs.svh
// register map, field positions and reset values of the alarm and mode block
// assumes 32-bit word registers on byte offsets, plain strobe port
`ifndef PMU_ALARM_REGS_SVH
`define PMU_ALARM_REGS_SVH
`define OFS_SYS_CTRL 8'h00
`define OFS_TMP_LIMIT 8'h04
`define OFS_ALARM_STAT 8'h08
`define OFS_IRQ_STAT 8'h0c
`define OFS_IRQ_MASK 8'h10
`define PMU_REG_PAGE 4'h2
`define PMU_CLR_BIT 6
`define AST_TMP_LAT 16
`define AST_TMP_LIVE 17
`define SYS_CTRL_RST 32'h0000_0000
`define TMP_LIMIT_RST 8'h82
`define IRQ_MASK_RST 3'h0
`endif

//--- inc/pmu_alarm_pkg.sv
// types shared by the alarm and mode block
// assumes nothing beyond a SystemVerilog tool
package pmu_alarm_pkg;
   typedef enum logic [1:0] {
      MEAS_VOLT = 2'h0,
      MEAS_CURR = 2'h1,
      MEAS_TEMP = 2'h3
   } meas_src_t;

   typedef struct packed {
      logic [7:0] rsv3;
      logic [7:0] meas_sel;
      logic [3:0] rsv2;
      logic [3:0] gnd_own;
      logic [2:0] rsv1;
      logic comp_keep;
      logic clamp_en;
      logic guard_en;
      logic cg_latch;
      logic cg_en;
   } sys_ctrl_t;

   typedef struct packed {
      logic [3:0] gnd_own;
      logic [3:0] guard_from_hs;
      meas_src_t [3:0] meas_sel;
   } route_t;

   typedef struct packed {
      logic clamp;
      logic guard;
      logic temp;
   } irq_t;
endpackage

//--- src/pmu_alarm_ctrl.sv
// alarm, mode-pin and routing control of a four-channel measurement unit
// assumes one 10 MHz clock; alarm and select pins are asynchronous, the
// die temperature code comes from logic on the same clock
`timescale 1ns/1ps
`include "pmu_alarm_regs.svh"

module pmu_alarm_ctrl import pmu_alarm_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic if_select_pin,
   input wire logic [3:0] guard_alarm_pin,
   input wire logic [3:0] clamp_alarm_pin,
   input wire logic [7:0] die_temp_c,
   output logic spi_mode,
   output logic comp_pins_as_link,
   output logic guard_clamp_alarm_out_o,
   output logic guard_clamp_alarm_out_oe,
   output logic temperature_alarm_out_o,
   output logic temperature_alarm_out_oe,
   output route_t route,
   output logic irq
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [8:0] pin_v;
   logic [8:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
   logic [3:0] guard_live, clamp_live;
   logic lvds;

   assign pin_v = {if_select_pin, clamp_alarm_pin, guard_alarm_pin};

   // a level counts only once two later stages agree
   genvar gi;
   generate
      for (gi = 0; gi < 9; gi++) begin : g_sync
         assign filt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : filt_r[gi];
      end
   endgenerate

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_r <= 9'h000;
         s2_r <= 9'h000;
         s3_r <= 9'h000;
         filt_r <= 9'h000;
      end else begin
         s1_r <= pin_v;
         s2_r <= s1_r;
         s3_r <= s2_r;
         filt_r <= filt_nxt;
      end
   end

   assign guard_live = filt_r[3:0];
   assign clamp_live = filt_r[7:4];
   assign lvds = filt_r[8];

   // ------------------------------------------------------------
   // registers and alarm flags
   // ------------------------------------------------------------
   sys_ctrl_t ctrl_r, ctrl_nxt;
   logic [7:0] limit_r, limit_nxt;
   logic [3:0] guard_lat_r, guard_lat_nxt, clamp_lat_r, clamp_lat_nxt;
   logic [3:0] guard_d_r, clamp_d_r;
   logic temp_lat_r, temp_lat_nxt, temp_d_r;
   irq_t istat_r, istat_nxt, imask_r, imask_nxt, ev;
   logic [31:0] rdata_nxt;
   logic temp_live, clr_hit, cg_assert;
   logic [3:0] g_src, c_src;

   assign temp_live = die_temp_c > limit_r;
   assign clr_hit = wr && (addr[7:4] == `PMU_REG_PAGE) && (addr[1:0] == 2'h0)
                    && wdata[`PMU_CLR_BIT];

   always_comb begin
      ctrl_nxt = ctrl_r;
      limit_nxt = limit_r;
      imask_nxt = imask_r;
      if (wr && addr == `OFS_SYS_CTRL) begin
         ctrl_nxt = sys_ctrl_t'(wdata);
      end
      if (wr && addr == `OFS_TMP_LIMIT) begin
         limit_nxt = wdata[7:0];
      end
      if (wr && addr == `OFS_IRQ_MASK) begin
         imask_nxt = irq_t'(wdata[2:0]);
      end
      // live condition beats a clear in the same cycle
      guard_lat_nxt = guard_live | (clr_hit ? 4'h0 : guard_lat_r);
      clamp_lat_nxt = clamp_live | (clr_hit ? 4'h0 : clamp_lat_r);
      temp_lat_nxt = temp_live | (clr_hit ? 1'b0 : temp_lat_r);
      ev.temp = temp_live & ~temp_d_r;
      ev.guard = |(guard_live & ~guard_d_r);
      ev.clamp = |(clamp_live & ~clamp_d_r);
      istat_nxt = ev | ((rd && addr == `OFS_IRQ_STAT) ? 3'h0 : istat_r);
      rdata_nxt = 32'h0000_0000;
      if (rd) begin
         unique case (addr)
            `OFS_SYS_CTRL: rdata_nxt = ctrl_r;
            `OFS_TMP_LIMIT: rdata_nxt = {24'h000000, limit_r};
            `OFS_ALARM_STAT: rdata_nxt = {14'h0000, temp_live, temp_lat_r,
                                          clamp_live, clamp_lat_r,
                                          guard_live, guard_lat_r};
            `OFS_IRQ_STAT: rdata_nxt = {29'h0000_0000, istat_r};
            `OFS_IRQ_MASK: rdata_nxt = {29'h0000_0000, imask_r};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= `SYS_CTRL_RST;
         limit_r <= `TMP_LIMIT_RST;
         imask_r <= `IRQ_MASK_RST;
         guard_lat_r <= 4'h0;
         clamp_lat_r <= 4'h0;
         temp_lat_r <= 1'b0;
         guard_d_r <= 4'h0;
         clamp_d_r <= 4'h0;
         temp_d_r <= 1'b0;
         istat_r <= 3'h0;
         rdata <= 32'h0000_0000;
      end else begin
         ctrl_r <= ctrl_nxt;
         limit_r <= limit_nxt;
         imask_r <= imask_nxt;
         guard_lat_r <= guard_lat_nxt;
         clamp_lat_r <= clamp_lat_nxt;
         temp_lat_r <= temp_lat_nxt;
         guard_d_r <= guard_live;
         clamp_d_r <= clamp_live;
         temp_d_r <= temp_live;
         istat_r <= istat_nxt;
         rdata <= rdata_nxt;
      end
   end

   // ------------------------------------------------------------
   // pins and routing
   // ------------------------------------------------------------
   route_t route_nxt;
   logic spi_nxt, link_nxt, cg_nxt, irq_nxt;

   // held flags count only in latch mode, so follow mode tracks live state
   assign g_src = guard_live | (ctrl_r.cg_latch ? guard_lat_r : 4'h0);
   assign c_src = clamp_live | (ctrl_r.cg_latch ? clamp_lat_r : 4'h0);
   assign cg_assert = ctrl_r.cg_en && ((ctrl_r.guard_en && |g_src)
                      || (ctrl_r.clamp_en && |c_src));

   always_comb begin
      spi_nxt = ~lvds;
      link_nxt = lvds & ~ctrl_r.comp_keep;
      cg_nxt = cg_assert;
      irq_nxt = |(istat_r & imask_r);
      route_nxt.gnd_own = ctrl_r.gnd_own;
      route_nxt.guard_from_hs = ctrl_r.gnd_own;
      for (int c = 0; c < 4; c++) begin
         // unused code 2 falls back to voltage sense
         unique case (ctrl_r.meas_sel[2*c +: 2])
            2'h1: route_nxt.meas_sel[c] = MEAS_CURR;
            2'h3: route_nxt.meas_sel[c] = MEAS_TEMP;
            default: route_nxt.meas_sel[c] = MEAS_VOLT;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         spi_mode <= 1'b1;
         comp_pins_as_link <= 1'b0;
         guard_clamp_alarm_out_oe <= 1'b0;
         irq <= 1'b0;
         route <= '0;
      end else begin
         spi_mode <= spi_nxt;
         comp_pins_as_link <= link_nxt;
         guard_clamp_alarm_out_oe <= cg_nxt;
         irq <= irq_nxt;
         route <= route_nxt;
      end
   end

   // open-drain pins only ever pull low
   assign guard_clamp_alarm_out_o = 1'b0;
   assign temperature_alarm_out_o = 1'b0;
   assign temperature_alarm_out_oe = temp_lat_r;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_sel;
      lvds |=> !spi_mode;
   endproperty
   a_sel: assert property (p_sel) else $error("select high kept serial mode");

   property p_link;
      (lvds && !ctrl_r.comp_keep) |=> comp_pins_as_link;
   endproperty
   a_link: assert property (p_link) else $error("comparator pins not on link");

   property p_off;
      !ctrl_r.cg_en |=> !guard_clamp_alarm_out_oe;
   endproperty
   a_off: assert property (p_off) else $error("disabled alarm pin driven");

   property p_follow;
      (ctrl_r.cg_en && !ctrl_r.cg_latch && !(|guard_live) && !(|clamp_live))
         |=> !guard_clamp_alarm_out_oe;
   endproperty
   a_follow: assert property (p_follow) else $error("follow mode held alarm");

   property p_src;
      (ctrl_r.cg_en && ctrl_r.guard_en && !ctrl_r.clamp_en && |guard_live)
         |=> guard_clamp_alarm_out_oe;
   endproperty
   a_src: assert property (p_src) else $error("guard alarm not shown");

   property p_csrc;
      (ctrl_r.cg_en && ctrl_r.clamp_en && !ctrl_r.guard_en && |clamp_live)
         |=> guard_clamp_alarm_out_oe;
   endproperty
   a_csrc: assert property (p_csrc) else $error("clamp alarm not shown");

   property p_lat;
      guard_live[0] |=> guard_lat_r[0];
   endproperty
   a_lat: assert property (p_lat) else $error("guard flag not latched");

   // only a clear may drop a held guard flag
   property p_glat;
      (guard_lat_r[0] && !clr_hit) |=> guard_lat_r[0];
   endproperty
   a_glat: assert property (p_glat) else $error("guard flag lost without clear");

   property p_tmp;
      temp_live |=> temperature_alarm_out_oe;
   endproperty
   a_tmp: assert property (p_tmp) else $error("temperature pin not low");

   property p_stat;
      (rd && addr == `OFS_ALARM_STAT) |=> rdata[`AST_TMP_LAT] == $past(temp_lat_r);
   endproperty
   a_stat: assert property (p_stat) else $error("latched temp flag misread");

   property p_live;
      (rd && addr == `OFS_ALARM_STAT) |=> rdata[`AST_TMP_LIVE] == $past(temp_live);
   endproperty
   a_live: assert property (p_live) else $error("live temp flag misread");

   property p_hold;
      (temp_lat_r && !clr_hit) |=> temp_lat_r;
   endproperty
   a_hold: assert property (p_hold) else $error("temp latch lost without clear");

   property p_clr;
      (clr_hit && !temp_live) |=> !temp_lat_r;
   endproperty
   a_clr: assert property (p_clr) else $error("clear bit ignored");

   property p_gnd;
      1'b1 |=> (route.guard_from_hs == $past(ctrl_r.gnd_own))
               && (route.gnd_own == $past(ctrl_r.gnd_own));
   endproperty
   a_gnd: assert property (p_gnd) else $error("guard source not tied to ground use");

   property p_meas;
      (ctrl_r.meas_sel[1:0] == 2'h3) |=> route.meas_sel[0] == MEAS_TEMP;
   endproperty
   a_meas: assert property (p_meas) else $error("measure mux ch0 wrong");

   property p_cg;
      cg_assert |=> guard_clamp_alarm_out_oe;
   endproperty
   a_cg: assert property (p_cg) else $error("alarm pin not pulled");

   c_tmp_clr: cover property (temp_lat_r ##1 clr_hit ##1 !temp_lat_r);
   c_cg_hold: cover property (ctrl_r.cg_latch && guard_clamp_alarm_out_oe && !(|guard_live));
   c_lvds: cover property (comp_pins_as_link);
   c_irq: cover property ($rose(irq));

endmodule

//--- test/host_model.sv
// host controller model driving the register port of the alarm block
// assumes one clock shared with the block and a slave that never waits
`timescale 1ns/1ps

module host_model (
   input wire logic clk,
   output logic [7:0] addr,
   output logic [31:0] wdata,
   output logic wr,
   output logic rd,
   input wire logic [31:0] rdata
);
   initial begin
      addr = 8'h00;
      wdata = 32'h0000_0000;
      wr = 1'b0;
      rd = 1'b0;
   end

   // ------------------------------------------------
   // bus cycles
   // ------------------------------------------------
   // released lines show inverted values so stale data never looks valid
   task automatic write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask

   task automatic read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
      #1;
      d = rdata;
   endtask
endmodule

//--- test/pmu_alarm_ctrl_test.sv
// self-checking bench of the alarm, mode-pin and routing block
// assumes the host model for bus cycles; pins settle within 6 edges
`timescale 1ns/1ps
`include "pmu_alarm_regs.svh"

module pmu_alarm_ctrl_test import pmu_alarm_pkg::*;;
   logic clk, rst, wr, rd, if_select_pin, spi_mode, comp_pins_as_link, irq;
   logic cg_o, cg_oe, tmp_o, tmp_oe;
   logic [3:0] guard_alarm_pin, clamp_alarm_pin;
   logic [7:0] die_temp_c, addr;
   logic [31:0] wdata, rdata, rv;
   route_t route;
   int errors, cmp_count;

   pmu_alarm_ctrl pmu_alarm_ctrl_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .if_select_pin(if_select_pin),
      .guard_alarm_pin(guard_alarm_pin), .clamp_alarm_pin(clamp_alarm_pin),
      .die_temp_c(die_temp_c), .spi_mode(spi_mode), .comp_pins_as_link(comp_pins_as_link),
      .guard_clamp_alarm_out_o(cg_o), .guard_clamp_alarm_out_oe(cg_oe),
      .temperature_alarm_out_o(tmp_o), .temperature_alarm_out_oe(tmp_oe),
      .route(route), .irq(irq));
   host_model host_model_i (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata));

   always #50 clk = ~clk;

   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // pin paths need up to 6 edges, so 8 leaves margin
   task automatic settle;
      repeat (8) @(posedge clk);
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      host_model_i.read(a, rv);
      chk(rv, exp);
   endtask

   task automatic wr_set(input logic [7:0] a, input logic [31:0] d);
      host_model_i.write(a, d);
      settle;
   endtask

   task automatic end_of_test;
      $display("comparisons %0d errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      end_of_test;
   end

   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      if_select_pin = 1'b0;
      guard_alarm_pin = 4'h0;
      clamp_alarm_pin = 4'h0;
      die_temp_c = 8'h19;
      errors = 0;
      cmp_count = 0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk(spi_mode, 1'b1);
      chk(cg_oe, 1'b0);
      chk(route, 16'h0000);
      rd_chk(`OFS_SYS_CTRL, `SYS_CTRL_RST);
      rd_chk(`OFS_TMP_LIMIT, 32'h0000_0082);
      rd_chk(8'h3c, 32'h0000_0000);
      @(posedge clk) if_select_pin <= 1'b1;
      settle;
      chk(spi_mode, 1'b0);
      chk(comp_pins_as_link, 1'b1);
      wr_set(`OFS_SYS_CTRL, 32'h0000_0010);
      chk(comp_pins_as_link, 1'b0);
      @(posedge clk) if_select_pin <= 1'b0;
      settle;
      chk(spi_mode, 1'b1);
      // guard alarm while output still disabled
      @(posedge clk) guard_alarm_pin <= 4'h2;
      settle;
      chk(cg_oe, 1'b0);
      chk(irq, 1'b0);
      rd_chk(`OFS_ALARM_STAT, 32'h0000_0022);
      wr_set(`OFS_SYS_CTRL, 32'h0000_0005);
      chk(cg_oe, 1'b1);
      @(posedge clk) guard_alarm_pin <= 4'h0;
      settle;
      chk(cg_oe, 1'b0);
      rd_chk(`OFS_ALARM_STAT, 32'h0000_0002);
      wr_set(`OFS_SYS_CTRL, 32'h0000_0007);
      chk(cg_oe, 1'b1);
      chk(cg_o, 1'b0);
      wr_set(8'h20, 32'h0000_0040);
      chk(cg_oe, 1'b0);
      // clamp only selected: guard events must not reach the pin
      wr_set(`OFS_SYS_CTRL, 32'h0000_0009);
      @(posedge clk) guard_alarm_pin <= 4'h1;
      settle;
      chk(cg_oe, 1'b0);
      @(posedge clk) clamp_alarm_pin <= 4'h8;
      settle;
      chk(cg_oe, 1'b1);
      @(posedge clk) clamp_alarm_pin <= 4'h0;
      settle;
      chk(cg_oe, 1'b0);
      rd_chk(`OFS_ALARM_STAT, 32'h0000_0811);
      wr_set(`OFS_IRQ_MASK, 32'h0000_0001);
      rd_chk(`OFS_IRQ_STAT, 32'h0000_0006);
      // over-temperature against the default limit
      @(posedge clk) die_temp_c <= 8'h83;
      settle;
      chk(tmp_oe, 1'b1);
      chk(irq, 1'b1);
      rd_chk(`OFS_ALARM_STAT, 32'h0003_0811);
      @(posedge clk) die_temp_c <= 8'h82;
      settle;
      chk(tmp_oe, 1'b1);
      rd_chk(`OFS_ALARM_STAT, 32'h0001_0811);
      rd_chk(`OFS_IRQ_STAT, 32'h0000_0001);
      repeat (3) @(posedge clk);
      #1;
      chk(irq, 1'b0);
      wr_set(8'h24, 32'hffff_ffbf);
      chk(tmp_oe, 1'b1);
      wr_set(8'h2c, 32'h0000_0040);
      chk(tmp_oe, 1'b0);
      chk(tmp_o, 1'b0);
      // guard pin 0 is still active, so its flags survive the clear
      rd_chk(`OFS_ALARM_STAT, 32'h0000_0011);
      // a temperature equal to the limit is not over it
      @(posedge clk) die_temp_c <= 8'h64;
      wr_set(`OFS_TMP_LIMIT, 32'h0000_0064);
      chk(tmp_oe, 1'b0);
      @(posedge clk) die_temp_c <= 8'h65;
      settle;
      chk(tmp_oe, 1'b1);
      // routing: ch0 current, ch1 temperature, ch2 voltage, ch3 code 2
      wr_set(`OFS_SYS_CTRL, 32'h008d_0500);
      chk(route, {4'h5, 4'h5, MEAS_VOLT, MEAS_VOLT, MEAS_TEMP, MEAS_CURR});
      rd_chk(`OFS_SYS_CTRL, 32'h008d_0500);
      chk(route.guard_from_hs, 4'h5);
      // second reset in mid-run
      @(posedge clk) rst <= 1'b1;
      @(posedge clk) #1;
      chk(tmp_oe, 1'b0);
      chk(route, 16'h0000);
      @(posedge clk) rst <= 1'b0;
      rd_chk(`OFS_TMP_LIMIT, 32'h0000_0082);
      end_of_test;
   end
endmodule
